// ---- core/buck_cfg_defines.svh ----
// constants of the converter configuration register bank
// Function
// [RQ1] The frequency field D[7:5] of control_settings_a selects 2.2, 2, 1.67, 1.25 (default), 1.11 or 0.85 MHz.
// [RQ2] Host software never writes the frequency codes 011 or 111.
// [RQ3] The speed field D[4:3] selects ultra-fast, fast (default), normal or slow transient response.
// [RQ4] With window_both_sides at 0 power-ok reacts only to undervoltage, at 1 to both directions.
// [RQ5] With input_overvoltage_disable at 0 the converter stops on input overvoltage, at 1 it ignores it.
// [RQ6] Bit 0 of control_settings_a at 0 allows pulse-skip operation, at 1 forces continuous conduction.
// [RQ7] Every write of the trigger bit D[5] of control_settings_b launches an output transition.
// [RQ8] The discharge bit D[4] at 1 turns on the internal pull-down, at 0 leaves discharge to the load; the code turns it on only while stopped.
// [RQ9] The ramp bit D[2] sets the reference slope to 32 mV/us at 0 and 8 mV/us at 1.
// [RQ10] identity_word_a returns a fixed maker code above a fixed part type code and is read-only.
// [RQ11] identity_word_b returns a fixed revision in its low nibble; the high nibble is reserved.
// [RQ12] The host writes control_settings_b only with single-byte accesses, never in a burst.
// [RQ13] The converter runs only while both the enable pin and the register enable bit are high.
// [RQ14] Reserved bits ignore writes and read back their fixed default values.
`ifndef BUCK_CFG_DEFINES_SVH
`define BUCK_CFG_DEFINES_SVH

`define ADDR_CONTROL_A     8'h02
`define ADDR_CONTROL_B     8'h03
`define ADDR_IDENTITY_A    8'h04
`define ADDR_IDENTITY_B    8'h05

`define RESET_CONTROL_A    8'h8C
`define RESET_CONTROL_B    8'h01
`define WRITE_MASK_B       8'h34
`define IDENTITY_B_RSVD    4'h0

`define BIT_TRIGGER        5
`define BIT_DISCHARGE      4
`define BIT_SLOW_RAMP      2

`define CLK_PERIOD_PS      5000
`define FREQ_2200_KHZ      2200
`define FREQ_2000_KHZ      2000
`define FREQ_1670_KHZ      1670
`define FREQ_1250_KHZ      1250
`define FREQ_1110_KHZ      1110
`define FREQ_850_KHZ       850
`define SW_CYCLES(khz)     (1000000000 / ((khz) * `CLK_PERIOD_PS))

`define REF_STEP_UV        5000
`define SLEW_FAST_MV_US    32
`define SLEW_SLOW_MV_US    8
`define STEP_CYCLES(mvus)  ((`REF_STEP_UV * 1000) / ((mvus) * `CLK_PERIOD_PS))

`endif

// ---- core/buck_cfg_pkg.sv ----
// types shared by the converter configuration register bank
package buck_cfg_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  typedef enum logic [2:0] {
    FREQ_2200 = 3'h0,
    FREQ_2000 = 3'h1,
    FREQ_1670 = 3'h2,
    FREQ_NONE3 = 3'h3,
    FREQ_1250 = 3'h4,
    FREQ_1110 = 3'h5,
    FREQ_850  = 3'h6,
    FREQ_NONE7 = 3'h7
  } freq_code_type;

  typedef enum logic [1:0] {
    RESP_ULTRA  = 2'h0,
    RESP_FAST   = 2'h1,
    RESP_NORMAL = 2'h2,
    RESP_SLOW   = 2'h3
  } response_type;

  typedef struct packed {
    freq_code_type freq;
    response_type  response;
    logic          window_both_sides;
    logic          input_overvoltage_disable;
    logic          force_continuous;
  } ctrl_a_type;

  typedef struct packed {
    logic         run;
    logic         pulse_skip_operation;
    logic         discharge_on;
    logic         slow_ramp;
    response_type response;
  } converter_ctrl_type;

  typedef enum logic [0:0] {
    RAMP_IDLE = 1'b0,
    RAMP_RUN  = 1'b1
  } ramp_state_type;

endpackage

// ---- core/buck_converter_config_regs.sv ----
// configuration and identity register bank of the step-down converter
`include "buck_cfg_defines.svh"

module buck_converter_config_regs
  import buck_cfg_pkg::*;
#(
  parameter logic [3:0] MAKER_CODE       = 4'hA,  // arbitrary value
  parameter logic [3:0] PART_TYPE_CODE   = 4'h5,  // arbitrary value
  parameter logic [3:0] SILICON_REVISION = 4'h3   // arbitrary value
) (
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire reg_req_type        reg_req,
  output logic [7:0]              rdata,
  output logic                    rd_valid,
  input  wire logic               enable_pin,
  input  wire logic               enable_bit,
  input  wire logic               vin_over_max,
  input  wire logic               vout_below,
  input  wire logic               vout_above,
  input  wire logic [6:0]         ramp_steps,
  output converter_ctrl_type      conv_ctrl,
  output logic                    sw_tick,
  output logic                    transition_start,
  output logic                    ref_step,
  output logic                    ramp_busy,
  input  wire logic               power_ok_output_i,
  output logic                    power_ok_output_o,
  output logic                    power_ok_output_oe,
  output logic                    power_ok_seen
);

  localparam logic [7:0] SW_2200  = 8'(`SW_CYCLES(`FREQ_2200_KHZ));
  localparam logic [7:0] SW_2000  = 8'(`SW_CYCLES(`FREQ_2000_KHZ));
  localparam logic [7:0] SW_1670  = 8'(`SW_CYCLES(`FREQ_1670_KHZ));
  localparam logic [7:0] SW_1250  = 8'(`SW_CYCLES(`FREQ_1250_KHZ));
  localparam logic [7:0] SW_1110  = 8'(`SW_CYCLES(`FREQ_1110_KHZ));
  localparam logic [7:0] SW_850   = 8'(`SW_CYCLES(`FREQ_850_KHZ));
  localparam logic [7:0] STEP_FAST = 8'(`STEP_CYCLES(`SLEW_FAST_MV_US));
  localparam logic [7:0] STEP_SLOW = 8'(`STEP_CYCLES(`SLEW_SLOW_MV_US));

  // reset release through two flops
  logic [1:0] rst_sync_reg;
  logic       rst_n;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) rst_sync_reg <= 2'h0;
    else         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // register access decode
  wire sel_a  = reg_req.addr == `ADDR_CONTROL_A;
  wire sel_b  = reg_req.addr == `ADDR_CONTROL_B;
  wire sel_ia = reg_req.addr == `ADDR_IDENTITY_A;
  wire sel_ib = reg_req.addr == `ADDR_IDENTITY_B;
  wire wr_a   = reg_req.wr && sel_a;
  wire wr_b   = reg_req.wr && sel_b;
  wire go_wr  = wr_b && reg_req.wdata[`BIT_TRIGGER];  // RQ7

  logic [7:0] ctrl_a_reg;
  logic [7:0] ctrl_b_reg;
  ctrl_a_type ctrl_a;
  assign ctrl_a = ctrl_a_type'(ctrl_a_reg);

  // reserved bits of the second control register keep their default
  wire [7:0] ctrl_b_next = (reg_req.wdata & `WRITE_MASK_B) |
                           (`RESET_CONTROL_B & ~`WRITE_MASK_B);  // RQ14

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_a_reg <= `RESET_CONTROL_A;
      ctrl_b_reg <= `RESET_CONTROL_B;
    end else begin
      if (wr_a) ctrl_a_reg <= reg_req.wdata;
      if (wr_b) ctrl_b_reg <= ctrl_b_next;
    end
  end

  // identity words are constants; writes to them fall on nothing
  wire [7:0] id_a = {MAKER_CODE, PART_TYPE_CODE};              // RQ10
  wire [7:0] id_b = {`IDENTITY_B_RSVD, SILICON_REVISION};      // RQ11

  wire [7:0] rd_mux = sel_a  ? ctrl_a_reg :
                      sel_b  ? ctrl_b_reg :
                      sel_ia ? id_a :
                      sel_ib ? id_b : 8'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata    <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= reg_req.rd;
      if (reg_req.rd) rdata <= rd_mux;
    end
  end

  // converter control
  wire ovp_trip = vin_over_max && !ctrl_a.input_overvoltage_disable;  // RQ5
  wire run      = enable_pin && enable_bit && !ovp_trip;             // RQ13
  wire slow     = ctrl_b_reg[`BIT_SLOW_RAMP];
  // pull-down only while stopped, so it never fights the power stage
  wire dis_on   = ctrl_b_reg[`BIT_DISCHARGE] && !run;                // RQ8

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_ctrl <= '0;
    end else begin
      conv_ctrl.run                  <= run;
      conv_ctrl.pulse_skip_operation <= run && !ctrl_a.force_continuous;  // RQ6
      conv_ctrl.discharge_on         <= dis_on;
      conv_ctrl.slow_ramp            <= slow;                            // RQ9
      conv_ctrl.response             <= ctrl_a.response;                 // RQ3
    end
  end

  // switching period; the two unassigned codes fall back to the default rate
  logic [7:0] sw_period;
  always_comb begin
    case (ctrl_a.freq)                                                   // RQ1
      FREQ_2200: sw_period = SW_2200;
      FREQ_2000: sw_period = SW_2000;
      FREQ_1670: sw_period = SW_1670;
      FREQ_1250: sw_period = SW_1250;
      FREQ_1110: sw_period = SW_1110;
      FREQ_850:  sw_period = SW_850;
      default:   sw_period = SW_1250;
    endcase
  end

  logic [7:0] sw_cnt_reg;
  wire        sw_wrap = sw_cnt_reg >= sw_period - 8'h01;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_cnt_reg <= 8'h00;
      sw_tick    <= 1'b0;
    end else begin
      sw_cnt_reg <= (!run || sw_wrap) ? 8'h00 : sw_cnt_reg + 8'h01;
      sw_tick    <= run && sw_wrap;
    end
  end

  // reference ramp: one step each step period, ramp_steps steps per transition
  ramp_state_type ramp_state_reg;
  ramp_state_type ramp_state_next;
  logic [7:0]     step_cnt_reg;
  logic [6:0]     steps_left_reg;
  wire [7:0]      step_period = slow ? STEP_SLOW : STEP_FAST;          // RQ9
  wire            step_due    = step_cnt_reg >= step_period - 8'h01;
  wire            last_step   = step_due && steps_left_reg <= 7'h01;

  always_comb begin
    case (ramp_state_reg)
      RAMP_IDLE: ramp_state_next = (go_wr && ramp_steps != 7'h00) ? RAMP_RUN : RAMP_IDLE;
      RAMP_RUN:  ramp_state_next = (last_step && !go_wr) ? RAMP_IDLE : RAMP_RUN;
      default:   ramp_state_next = RAMP_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ramp_state_reg   <= RAMP_IDLE;
      step_cnt_reg     <= 8'h00;
      steps_left_reg   <= 7'h00;
      transition_start <= 1'b0;
      ref_step         <= 1'b0;
    end else begin
      ramp_state_reg   <= ramp_state_next;
      transition_start <= go_wr;                                        // RQ7
      ref_step         <= ramp_state_reg == RAMP_RUN && step_due && !go_wr;
      if (go_wr) begin
        step_cnt_reg   <= 8'h00;
        steps_left_reg <= ramp_steps;
      end else if (ramp_state_reg == RAMP_RUN) begin
        step_cnt_reg   <= step_due ? 8'h00 : step_cnt_reg + 8'h01;
        if (step_due) steps_left_reg <= steps_left_reg - 7'h01;
      end
    end
  end
  assign ramp_busy = ramp_state_reg == RAMP_RUN;

  // power-ok, open drain: driven low while out of window or stopped
  wire pok = run && !vout_below && !(ctrl_a.window_both_sides && vout_above);  // RQ4
  logic pok_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) pok_reg <= 1'b0;
    else        pok_reg <= pok;
  end
  assign power_ok_output_o  = 1'b0;
  assign power_ok_output_oe = !pok_reg;
  assign power_ok_seen      = power_ok_output_i;

  // cycles since the last switching tick; all ones until a clean tick has been seen
  logic [8:0] tick_age_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_age_reg <= 9'h1FF;
    end else if (wr_a || !run) begin
      tick_age_reg <= 9'h1FF;
    end else if (sw_tick) begin
      tick_age_reg <= 9'h000;
    end else if (tick_age_reg != 9'h1FF) begin
      tick_age_reg <= tick_age_reg + 9'h001;
    end
  end

  // cycles since the last reference step; a control_settings_b write or an idle ramp drops the reference
  logic [8:0] step_age_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_age_reg <= 9'h1FF;
    end else if (go_wr || wr_b || !ramp_busy) begin
      step_age_reg <= 9'h1FF;
    end else if (ref_step) begin
      step_age_reg <= 9'h000;
    end else if (step_age_reg != 9'h1FF) begin
      step_age_reg <= step_age_reg + 9'h001;
    end
  end
  // 5 mV per step at 8 or 32 mV/us on a 5 ns clock
  wire [8:0] step_age_due = slow ? 9'h07C : 9'h01E;

  // checks
  AST_FREQ_DEFAULT: assert property (@(posedge clk) disable iff (!rst_n)  // RQ1
    (ctrl_a.freq == FREQ_1250 && tick_age_reg <= 9'h09F &&
     (sw_tick || tick_age_reg == 9'h09F)) |-> (sw_tick && tick_age_reg == 9'h09F))
    else $error("default switching period is not 160 cycles");
  AST_RESPONSE: assert property (@(posedge clk) disable iff (!rst_n)  // RQ3
    wr_a |=> ##1 conv_ctrl.response == $past(reg_req.wdata[4:3], 2))
    else $error("response speed does not follow the written field");
  AST_WINDOW: assert property (@(posedge clk) disable iff (!rst_n)  // RQ4
    (run && vout_above && !vout_below && !ctrl_a.window_both_sides) |=> !power_ok_output_oe)
    else $error("overshoot pulled power-ok with one-sided window");
  AST_WINDOW_BOTH: assert property (@(posedge clk) disable iff (!rst_n)  // RQ4
    (vout_above && ctrl_a.window_both_sides) |=> power_ok_output_oe)
    else $error("overshoot not flagged with two-sided window");
  AST_OVP: assert property (@(posedge clk) disable iff (!rst_n)  // RQ5
    (vin_over_max && !ctrl_a.input_overvoltage_disable) |=> !conv_ctrl.run)
    else $error("converter kept running through input overvoltage");
  AST_PULSE_SKIP: assert property (@(posedge clk) disable iff (!rst_n)  // RQ6
    (run && !ctrl_a.force_continuous) |=> conv_ctrl.pulse_skip_operation)
    else $error("pulse skip not enabled");
  AST_GO: assert property (@(posedge clk) disable iff (!rst_n)  // RQ7
    (reg_req.wr && reg_req.addr == `ADDR_CONTROL_B && reg_req.wdata[5]) |=> transition_start)
    else $error("trigger write did not launch a transition");
  AST_DISCHARGE: assert property (@(posedge clk) disable iff (!rst_n)  // RQ8
    (ctrl_b_reg[4] && !run) |=> conv_ctrl.discharge_on)
    else $error("discharge not enabled while stopped");
  AST_SLOW_STEP: assert property (@(posedge clk) disable iff (!rst_n)  // RQ9
    (ref_step && slow && ramp_busy && !go_wr) |-> ##1 (!ref_step [*8]))
    else $error("slow ramp stepped too early");
  AST_ID_A: assert property (@(posedge clk) disable iff (!rst_n)  // RQ10
    (reg_req.rd && sel_ia) |=> rdata == {MAKER_CODE, PART_TYPE_CODE})
    else $error("identity word a wrong");
  AST_ID_B: assert property (@(posedge clk) disable iff (!rst_n)  // RQ11
    (reg_req.rd && sel_ib) |=> rdata[7:4] == 4'h0 && rdata[3:0] == SILICON_REVISION)
    else $error("identity word b wrong");
  AST_ENABLE: assert property (@(posedge clk) disable iff (!rst_n)  // RQ13
    (!enable_pin || !enable_bit) |=> !conv_ctrl.run)
    else $error("converter runs with an enable low");
  AST_RSVD_B: assert property (@(posedge clk) disable iff (!rst_n)  // RQ14
    (ctrl_b_reg & ~`WRITE_MASK_B) == (`RESET_CONTROL_B & ~`WRITE_MASK_B))
    else $error("reserved bits of control b changed");
  AST_STEP_PERIOD: assert property (@(posedge clk) disable iff (!rst_n)  // RQ9
    (step_age_reg <= step_age_due && (ref_step || step_age_reg == step_age_due))
    |-> (ref_step && step_age_reg == step_age_due))
    else $error("reference step period differs from the slew rate");
  AST_RD_VALID: assert property (@(posedge clk) disable iff (!rst_n)  // RQ14
    reg_req.rd |=> rd_valid)
    else $error("read not answered in the next cycle");
  AST_RD_IDLE: assert property (@(posedge clk) disable iff (!rst_n)  // RQ14
    !reg_req.rd |=> !rd_valid)
    else $error("read valid without a read");
  AST_RD_CTRL_A: assert property (@(posedge clk) disable iff (!rst_n)  // RQ1
    (reg_req.rd && sel_a) |=> rdata == $past(ctrl_a_reg))
    else $error("control a read back wrong");
  AST_RD_UNMAPPED: assert property (@(posedge clk) disable iff (!rst_n)  // RQ14
    (reg_req.rd && !(sel_a || sel_b || sel_ia || sel_ib)) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_ID_RO: assert property (@(posedge clk) disable iff (!rst_n)  // RQ10
    (reg_req.wr && (sel_ia || sel_ib)) |=> $stable(ctrl_a_reg) && $stable(ctrl_b_reg))
    else $error("identity write changed a control register");
  AST_NO_GO: assert property (@(posedge clk) disable iff (!rst_n)  // RQ7
    (reg_req.wr && sel_b && !reg_req.wdata[5]) |=> !transition_start)
    else $error("transition launched without a trigger write");
  AST_STEP_IDLE: assert property (@(posedge clk) disable iff (!rst_n)  // RQ9
    !ramp_busy |=> !ref_step)
    else $error("reference step outside a ramp");
  AST_SLOW_FLAG: assert property (@(posedge clk) disable iff (!rst_n)  // RQ9
    ctrl_b_reg[2] |=> conv_ctrl.slow_ramp)
    else $error("slow ramp not passed on");
  AST_DISCHARGE_RUN: assert property (@(posedge clk) disable iff (!rst_n)  // RQ8
    conv_ctrl.run |-> !conv_ctrl.discharge_on)
    else $error("discharge on while running");
  AST_CONTINUOUS: assert property (@(posedge clk) disable iff (!rst_n)  // RQ6
    ctrl_a.force_continuous |=> !conv_ctrl.pulse_skip_operation)
    else $error("pulse skip with continuous conduction forced");
  AST_OVP_IGNORED: assert property (@(posedge clk) disable iff (!rst_n)  // RQ5
    (enable_pin && enable_bit && ctrl_a.input_overvoltage_disable) |=> conv_ctrl.run)
    else $error("converter stopped with overvoltage ignored");
  AST_RUN_ON: assert property (@(posedge clk) disable iff (!rst_n)  // RQ13
    (enable_pin && enable_bit && !vin_over_max) |=> conv_ctrl.run)
    else $error("converter off with both enables high");
  AST_OE_STOP: assert property (@(posedge clk) disable iff (!rst_n)  // RQ4
    !run |=> power_ok_output_oe)
    else $error("power ok released while stopped");

  COV_FREQ_CHANGE: cover property (@(posedge clk) disable iff (!rst_n) wr_a ##1 sw_tick);
  COV_SLOW_STEP:   cover property (@(posedge clk) disable iff (!rst_n) ref_step && slow);
  COV_RAMP_DONE:   cover property (@(posedge clk) disable iff (!rst_n) ramp_busy ##1 !ramp_busy);
  COV_OVP_TRIP:    cover property (@(posedge clk) disable iff (!rst_n) run ##1 ovp_trip);
  COV_ID_READ:     cover property (@(posedge clk) disable iff (!rst_n) reg_req.rd && sel_ia);

endmodule

// ---- test/buck_host_model.sv ----
// host-side model that issues single-byte register requests
module buck_host_model
  import buck_cfg_pkg::*;
(
  input  wire logic        clk,
  output reg_req_type      reg_req,
  input  wire logic [7:0]  rdata,
  input  wire logic        rd_valid
);
  timeunit 1ns;
  timeprecision 100ps;

  initial reg_req = '0;

  // requests are held across exactly one sampling edge, then released
  task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h02 && d[6:5] == 2'h3) return;
    @(posedge clk);
    #1 reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    #1 reg_req = '0;
  endtask

  task automatic read_byte(input logic [7:0] a, output logic [7:0] d, output logic ok);
    int n;
    ok = 1'b0;
    d = 8'h00;
    @(posedge clk);
    #1 reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    #1 reg_req = '0;
    for (n = 0; n < 4 && !ok; n++) begin
      if (rd_valid === 1'b1) begin
        ok = 1'b1;
        d = rdata;
      end else begin
        @(posedge clk);
        #1;
      end
    end
  endtask
endmodule

// ---- test/buck_converter_config_regs_tb_top.sv ----
// self-checking bench of the converter configuration register bank
`define CHK(name, exp, got) begin checked++; if ((got) !== (exp)) begin miscompares++; \
  $display("Error %s expected %0h seen %0h", name, exp, got); end end

module buck_converter_config_regs_tb_top
  import buck_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic               clk, resetn, enable_pin, enable_bit, vin_over_max;
  logic               vout_below, vout_above, rd_valid, pin_level;
  logic               sw_tick, transition_start, ref_step, ramp_busy;
  logic               power_ok_output_o, power_ok_output_oe, power_ok_seen;
  logic [6:0]         ramp_steps;
  logic [7:0]         rdata;
  reg_req_type        reg_req;
  converter_ctrl_type conv_ctrl;
  int                 checked, miscompares, i, n;
  // rows: address, written byte, byte read back
  logic [23:0]        rows [11] = '{24'h02_00_00, 24'h02_28_28, 24'h02_5A_5A, 24'h02_92_92,
    24'h02_BE_BE, 24'h02_C1_C1, 24'h03_FF_35, 24'h03_00_01, 24'h04_00_A5, 24'h05_FF_03,
    24'h10_FF_00};
  int                 periods [6] = '{90, 100, 119, 160, 180, 235};
  logic [2:0]         codes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};

  // open-drain indicator with a pull-up
  assign pin_level = power_ok_output_oe ? power_ok_output_o : 1'b1;

  buck_host_model host (.clk(clk), .reg_req(reg_req), .rdata(rdata), .rd_valid(rd_valid));

  buck_converter_config_regs DUT (.clk(clk), .resetn(resetn), .reg_req(reg_req),
    .rdata(rdata), .rd_valid(rd_valid), .enable_pin(enable_pin), .enable_bit(enable_bit),
    .vin_over_max(vin_over_max), .vout_below(vout_below), .vout_above(vout_above),
    .ramp_steps(ramp_steps), .conv_ctrl(conv_ctrl), .sw_tick(sw_tick),
    .transition_start(transition_start), .ref_step(ref_step), .ramp_busy(ramp_busy),
    .power_ok_output_i(pin_level), .power_ok_output_o(power_ok_output_o),
    .power_ok_output_oe(power_ok_output_oe), .power_ok_seen(power_ok_seen));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic results();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    host.read_byte(a, d, ok);
    if (!ok) begin
      miscompares++;
      results();
    end
    `CHK("read data", e, d)
  endtask

  function automatic logic pulse(input logic s);
    return s ? ref_step : sw_tick;
  endfunction

  // edges between two successive pulses of ref_step (s=1) or sw_tick (s=0)
  task automatic gap(input logic s, output int g);
    int k;
    for (k = 0; k < 600 && pulse(s) !== 1'b1; k++) cyc(1);
    g = 0;
    do begin
      cyc(1);
      g++;
    end while (g < 600 && pulse(s) !== 1'b1);
    if (k == 600 || g == 600) begin
      miscompares++;
      results();
    end
  endtask

  initial begin
    {resetn, vin_over_max, vout_below, vout_above} = '0;
    {enable_pin, enable_bit} = 2'b11;
    ramp_steps = 7'h03;
    cyc(10);
    `CHK("oe in reset", 1'b1, power_ok_output_oe)
    resetn = 1'b1;
    cyc(3);
    rd_chk(8'h02, 8'h8C);
    rd_chk(8'h03, 8'h01);
    for (i = 0; i < 11; i++) begin
      host.write_byte(rows[i][23:16], rows[i][15:8]);
      rd_chk(rows[i][23:16], rows[i][7:0]);
      if (rows[i][23:16] == 8'h02) `CHK("response", rows[i][12:11], conv_ctrl.response)
    end
    cyc(500);
    for (i = 0; i < 6; i++) begin
      host.write_byte(8'h02, {codes[i], 5'h0C});
      gap(1'b0, n);
      `CHK("switching period", periods[i], n)
    end
    for (i = 0; i < 2; i++) begin
      host.write_byte(8'h03, i[0] ? 8'h24 : 8'h20);
      `CHK("transition start", 1'b1, transition_start)
      `CHK("ramp busy", 1'b1, ramp_busy)
      gap(1'b1, n);
      `CHK("ramp step period", i[0] ? 125 : 31, n)
      `CHK("slow ramp", i[0], conv_ctrl.slow_ramp)
      cyc(140);
      `CHK("ramp done", 1'b0, ramp_busy)
    end
    host.write_byte(8'h03, 8'h00);
    `CHK("no trigger on zero", 1'b0, transition_start)
    for (i = 0; i < 4; i++) begin
      {enable_pin, enable_bit} = i[1:0];
      cyc(2);
      `CHK("run", i == 3, conv_ctrl.run)
    end
    vin_over_max = 1'b1;
    cyc(2);
    `CHK("overvoltage stop", 1'b0, conv_ctrl.run)
    host.write_byte(8'h02, 8'h8F);
    cyc(1);
    `CHK("overvoltage ignored", 1'b1, conv_ctrl.run)
    `CHK("continuous", 1'b0, conv_ctrl.pulse_skip_operation)
    vin_over_max = 1'b0;
    host.write_byte(8'h02, 8'h8C);
    cyc(1);
    `CHK("pulse skip", 1'b1, conv_ctrl.pulse_skip_operation)
    for (i = 0; i < 4; i++) begin
      vout_above = i < 2;
      vout_below = i == 2;
      host.write_byte(8'h02, i[0] | i[1] ? 8'h88 : 8'h8C);
      cyc(2);
      `CHK("power ok low", !i[0], power_ok_output_oe)
      `CHK("power ok seen", i[0], power_ok_seen)
    end
    {vout_above, vout_below} = '0;
    host.write_byte(8'h03, 8'h10);
    enable_pin = 1'b0;
    cyc(2);
    `CHK("discharge on", 1'b1, conv_ctrl.discharge_on)
    host.write_byte(8'h03, 8'h00);
    cyc(1);
    `CHK("discharge off", 1'b0, conv_ctrl.discharge_on)
    resetn = 1'b0;
    cyc(2);
    `CHK("oe in mid reset", 1'b1, power_ok_output_oe)
    resetn = 1'b1;
    cyc(3);
    rd_chk(8'h02, 8'h8C);
    rd_chk(8'h03, 8'h01);
    results();
  end
endmodule
